// [rtl/eipu_pkg.sv]
// package for the external pin interrupt unit: register map, field
// positions, sense encodings and timing constants.
// assumes a 20 MHz system clock and an apb master with 32-bit data.
package eipu_pkg;

	// ------------------------------------------------------------
	// register map (byte addresses on the apb bus)
	// ------------------------------------------------------------
	localparam int          ADDR_W            = 8;       // decoded address width
	localparam logic [7:0]  OFS_CPU_CONTROL   = 8'h00;   // pin 0/1 sense fields
	localparam logic [7:0]  OFS_CTRL_RST_STAT = 8'h04;   // pin 2 edge select
	localparam logic [7:0]  OFS_PIN_ENABLES   = 8'h08;   // per-pin enables
	localparam logic [7:0]  OFS_PIN_FLAGS     = 8'h0c;   // sticky flags, write one clears
	localparam logic [7:0]  OFS_PORT_D_LEVELS = 8'h10;   // live pin levels, read only

	// ------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------
	localparam int          POS_P1_SENSE_HI   = 3;       // pin one sense field 3:2
	localparam int          POS_P1_SENSE_LO   = 2;
	localparam int          POS_P0_SENSE_HI   = 1;       // pin zero sense field 1:0
	localparam int          POS_P0_SENSE_LO   = 0;
	localparam int          POS_P2_EDGE_SEL   = 6;       // pin two edge select
	localparam int          POS_P1_BIT        = 7;       // enable / flag of pin one
	localparam int          POS_P0_BIT        = 6;       // enable / flag of pin zero
	localparam int          POS_P2_BIT        = 5;       // enable / flag of pin two
	localparam int          POS_PORTD_P0      = 2;       // pin zero sits on port d bit 2
	localparam int          POS_PORTD_P1      = 3;       // pin one sits on port d bit 3

	// ------------------------------------------------------------
	// reset values
	// ------------------------------------------------------------
	localparam logic [7:0]  RST_CPU_CONTROL   = 8'h00;
	localparam logic        RST_P2_EDGE_SEL   = 1'b0;
	localparam logic [2:0]  RST_ENABLES       = 3'h0;
	localparam logic [2:0]  RST_FLAGS         = 3'h0;

	// ------------------------------------------------------------
	// sense encodings for pins zero and one
	// ------------------------------------------------------------
	localparam logic [1:0]  SENSE_LOW_LEVEL   = 2'h0;
	localparam logic [1:0]  SENSE_ANY_CHANGE  = 2'h1;
	localparam logic [1:0]  SENSE_FALLING     = 2'h2;
	localparam logic [1:0]  SENSE_RISING      = 2'h3;

	// ------------------------------------------------------------
	// timing
	// ------------------------------------------------------------
	localparam int          CLK_PERIOD_NS     = 50;      // 20 MHz system clock
	localparam int          WDT_PERIOD_NS     = 1000;    // watchdog oscillator period
	localparam int          WDT_TICK_CYC      = (WDT_PERIOD_NS + CLK_PERIOD_NS - 1)
	                                            / CLK_PERIOD_NS;
	localparam int          P2_MIN_PULSE_NS   = 50;      // narrowest pin two pulse caught
	localparam int          P2_MIN_PULSE_CYC  = P2_MIN_PULSE_NS / CLK_PERIOD_NS;
	localparam int          STARTUP_CYC_DEF   = 1000;    // start-up delay after wake
	localparam int          CNT_W             = 16;

	// wake sequencer states
	typedef enum logic [1:0] {
		WK_IDLE,
		WK_SAMPLE,
		WK_START
	} eipu_wake_t;

endpackage : eipu_pkg

// [rtl/eipu_pin_sync.sv]
// two-stage synchroniser plus one history stage for one interrupt pin.
// assumes the pin level is already resolved to a single bit.
`timescale 1ns/10ps
module eipu_pin_sync
	import eipu_pkg::*;
(
	// clock and reset
	input  wire logic clk_in,       // system clock
	input  wire logic rst_n_in,     // synchronised reset, active low
	// pin side
	input  wire logic level_in,     // raw pin level
	input  wire logic hold_in,      // freeze history, as a halted clock would
	// synchronised side
	output logic      level_out,    // synchronised level
	output logic      prev_out      // level one sample earlier
);

	logic meta;                    // first stage, read only by level_out

	// ------------------------------------------------------------
	// synchroniser: first flop feeds only the second
	// ------------------------------------------------------------
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			meta      <= 1'b1;
			level_out <= 1'b1;
		end else begin
			meta      <= level_in;
			level_out <= meta;
		end
	end

	// history stage; held while halted so a level change during a halt shows as an edge once it ends
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			prev_out <= 1'b1;
		end else if (!hold_in) begin
			prev_out <= level_out;
		end
	end

endmodule : eipu_pin_sync

// [rtl/eipu_top.sv]
// external pin interrupt unit: three pins, sense control, flags,
// per-vector requests and the power-down wake sequencer.
// assumes an apb master on clk_in and a cpu that supplies the global
// enable, vector acknowledge pulses and its sleep state.
//
// What this block does
// - pins still interrupt while driven as outputs
// - pins 0/1 edge and level; pin 2 edge
// - level mode requests while pin stays low
// - pin 0/1 edges need running io clock
// - level and pin 2 edge work halted
// - power-down level wake needs two watchdog samples
// - level gone before start-up end: wake, no request
// - request needs pin enable and global enable
// - pin 1 sense field at bits 3:2
// - pin 0 sense field at bits 1:0
// - sample pin first, then detect edges
// - pin 2 edge select at bit 6
// - pin 2 edges wider than 50 ns caught
// - enables at bits 7, 6, 5
// - one request output per pin vector
// - event sets flag; ack or one clears it
// - flags at bits 7, 6, 5, reset zero
`timescale 1ns/10ps
module eipu_top
	import eipu_pkg::*;
#(
	parameter logic [CNT_W-1:0] STARTUP_CYC = CNT_W'(STARTUP_CYC_DEF)
)(
	// clock and reset
	input  wire logic              clk_in,          // 20 MHz
	input  wire logic              resetn_in,       // async, active low
	// apb slave
	input  wire logic              psel_in,
	input  wire logic              penable_in,
	input  wire logic              pwrite_in,
	input  wire logic [ADDR_W-1:0] paddr_in,
	input  wire logic [31:0]       pwdata_in,
	output logic      [31:0]       prdata_out,
	output logic                   pready_out,
	output logic                   pslverr_out,
	// pins: index 0/1/2 = ext_irq_pin_zero/one/two
	input  wire logic [2:0]        pin_level_in,    // pad level
	input  wire logic [2:0]        pin_drive_en_in, // port drives the pin
	input  wire logic [2:0]        pin_drive_val_in,// value the port drives
	// cpu side
	input  wire logic              global_ie_in,    // cpu_status_word enable bit
	input  wire logic [2:0]        vector_ack_in,   // pulse: vector taken
	input  wire logic              io_clk_halt_in,  // sleep mode other than idle
	input  wire logic              power_down_in,   // power-down sleep
	output logic      [2:0]        irq_out,         // one request per vector
	output logic                   wake_out         // pulse: start-up complete
);

	// ------------------------------------------------------------
	// reset release
	// ------------------------------------------------------------
	logic       rst_q1;           // first release stage
	logic       rst_n;            // design reset

	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			rst_q1 <= 1'b0;
			rst_n  <= 1'b0;
		end else begin
			rst_q1 <= 1'b1;
			rst_n  <= rst_q1;
		end
	end

	// ------------------------------------------------------------
	// registers and state
	// ------------------------------------------------------------
	logic [7:0]       cpu_control;   // sense fields, upper bits general storage
	logic             p2_edge_sel;   // 0 falling, 1 rising
	logic [2:0]       enables;       // index order pin0, pin1, pin2
	logic [2:0]       flags;         // same order
	logic [2:0]       pin_eff;       // level seen by the detectors
	logic [2:0]       lvl;           // synchronised levels
	logic [2:0]       prv;           // previous synchronised levels
	logic [2:0]       event_vec;     // edge events this cycle
	logic [2:0]       level_mode;    // pin in low-level mode
	logic [2:0]       clr_vec;       // flag clears this cycle
	logic [2:0]       level_req;     // live level requests
	logic [1:0]       sense [2];     // sense fields of pins 0/1
	logic             wr_en;         // apb write takes effect
	logic             setup;         // apb setup cycle
	logic [31:0]      next_rdata;    // read mux
	logic             next_err;      // unmapped address
	logic [4:0]       wdt_cnt;       // watchdog oscillator divider
	logic             wdt_tick;      // one-cycle watchdog sample enable
	logic             level_wake;    // enabled level condition present
	logic [CNT_W-1:0] start_cnt;     // start-up counter
	eipu_wake_t       wake_state;

	// the detectors see what the pad carries, or what the port drives on it,
	// so software can raise an interrupt by writing the pin
	always_comb begin
		for (int i = 0; i < 3; i++) begin
			pin_eff[i] = pin_drive_en_in[i] ? pin_drive_val_in[i] : pin_level_in[i];
		end
	end

	// ------------------------------------------------------------
	// pin synchronisers
	// ------------------------------------------------------------
	// pins 0/1 freeze with the io clock; pin 2 keeps running because
	// its edge capture does not depend on the io clock
	genvar g;
	generate
		for (g = 0; g < 3; g++) begin : g_sync
			eipu_pin_sync u_sync (
				.clk_in    (clk_in),
				.rst_n_in  (rst_n),
				.level_in  (pin_eff[g]),
				.hold_in   ((g < 2) ? io_clk_halt_in : 1'b0),
				.level_out (lvl[g]),
				.prev_out  (prv[g])
			);
		end
	endgenerate

	// ------------------------------------------------------------
	// sense decode and edge detection
	// ------------------------------------------------------------
	assign sense[0] = cpu_control[POS_P0_SENSE_HI:POS_P0_SENSE_LO];
	assign sense[1] = cpu_control[POS_P1_SENSE_HI:POS_P1_SENSE_LO];

	always_comb begin
		for (int i = 0; i < 2; i++) begin
			level_mode[i] = (sense[i] == SENSE_LOW_LEVEL);
			// edges are taken from sampled values only
			unique case (sense[i])
				SENSE_ANY_CHANGE: event_vec[i] = lvl[i] ^ prv[i];
				SENSE_FALLING:    event_vec[i] = prv[i] & ~lvl[i];
				SENSE_RISING:     event_vec[i] = ~prv[i] & lvl[i];
				SENSE_LOW_LEVEL:  event_vec[i] = 1'b0;      // low level: no edge
			endcase
			// no edge while the io clock is halted
			if (io_clk_halt_in) begin
				event_vec[i] = 1'b0;
			end
		end
		// pin 2 is edge only; every 50 ns clock samples it, so a pulse
		// wider than one period always spans a sample
		level_mode[2] = 1'b0;
		event_vec[2]  = p2_edge_sel ? (~prv[2] & lvl[2]) : (prv[2] & ~lvl[2]);
	end

	// ------------------------------------------------------------
	// apb slave: no wait state, pready from a flop
	// ------------------------------------------------------------
	assign setup = psel_in & ~penable_in;
	assign wr_en = psel_in & penable_in & pready_out & pwrite_in & ~pslverr_out;

	// read mux, captured in the setup cycle
	always_comb begin
		next_rdata = 32'h0;
		next_err   = 1'b0;
		unique case (paddr_in)
			OFS_CPU_CONTROL:   next_rdata[7:0] = cpu_control;
			OFS_CTRL_RST_STAT: next_rdata[POS_P2_EDGE_SEL] = p2_edge_sel;
			OFS_PIN_ENABLES: begin
				next_rdata[POS_P0_BIT] = enables[0];
				next_rdata[POS_P1_BIT] = enables[1];
				next_rdata[POS_P2_BIT] = enables[2];
			end
			OFS_PIN_FLAGS: begin
				next_rdata[POS_P0_BIT] = flags[0];
				next_rdata[POS_P1_BIT] = flags[1];
				next_rdata[POS_P2_BIT] = flags[2];
			end
			OFS_PORT_D_LEVELS: begin
				next_rdata[POS_PORTD_P0] = lvl[0];
				next_rdata[POS_PORTD_P1] = lvl[1];
			end
			default:           next_err = 1'b1;      // unmapped: error, data zero
		endcase
	end

	// bus answer flops
	always_ff @(posedge clk_in or negedge rst_n) begin
		if (!rst_n) begin
			pready_out  <= 1'b0;
			pslverr_out <= 1'b0;
			prdata_out  <= 32'h0;
		end else begin
			pready_out  <= setup;
			pslverr_out <= setup & next_err;
			if (setup && !pwrite_in) begin
				prdata_out <= next_rdata;
			end
		end
	end

	// control register writes
	always_ff @(posedge clk_in or negedge rst_n) begin
		if (!rst_n) begin
			cpu_control <= RST_CPU_CONTROL;
			p2_edge_sel <= RST_P2_EDGE_SEL;
			enables     <= RST_ENABLES;
		end else if (wr_en) begin
			if (paddr_in == OFS_CPU_CONTROL) begin
				cpu_control <= pwdata_in[7:0];
			end
			// a change here alone raises no event, since one needs prv[2] and lvl[2]
			// to differ; software may still mask pin 2 first and clear its flag afterwards
			if (paddr_in == OFS_CTRL_RST_STAT) begin
				p2_edge_sel <= pwdata_in[POS_P2_EDGE_SEL];
			end
			if (paddr_in == OFS_PIN_ENABLES) begin
				enables[0] <= pwdata_in[POS_P0_BIT];
				enables[1] <= pwdata_in[POS_P1_BIT];
				enables[2] <= pwdata_in[POS_P2_BIT];
			end
		end
	end

	// ------------------------------------------------------------
	// sticky flags
	// ------------------------------------------------------------
	always_comb begin
		clr_vec = vector_ack_in;
		if (wr_en && paddr_in == OFS_PIN_FLAGS) begin
			clr_vec[0] = vector_ack_in[0] | pwdata_in[POS_P0_BIT];
			clr_vec[1] = vector_ack_in[1] | pwdata_in[POS_P1_BIT];
			clr_vec[2] = vector_ack_in[2] | pwdata_in[POS_P2_BIT];
		end
	end

	// level mode forces zero; otherwise a new event beats a clear
	always_ff @(posedge clk_in or negedge rst_n) begin
		if (!rst_n) begin
			flags <= RST_FLAGS;
		end else begin
			for (int i = 0; i < 3; i++) begin
				if (level_mode[i]) begin
					flags[i] <= 1'b0;
				end else if (event_vec[i]) begin
					flags[i] <= 1'b1;
				end else if (clr_vec[i]) begin
					flags[i] <= 1'b0;
				end
			end
		end
	end

	// ------------------------------------------------------------
	// requests toward the cpu
	// ------------------------------------------------------------
	// level requests are held back during power-down so a level that
	// vanishes before start-up ends leaves no request behind
	always_comb begin
		for (int i = 0; i < 3; i++) begin
			level_req[i] = level_mode[i] & ~lvl[i] & ~power_down_in;
		end
	end

	// one output per vector; the source must keep a level until the
	// current instruction ends, which the cpu side relies on
	always_ff @(posedge clk_in or negedge rst_n) begin
		if (!rst_n) begin
			irq_out <= 3'h0;
		end else begin
			irq_out <= (flags | level_req) & enables & {3{global_ie_in}};
		end
	end

	// ------------------------------------------------------------
	// watchdog oscillator divider
	// ------------------------------------------------------------
	assign wdt_tick = (wdt_cnt == 5'(WDT_TICK_CYC - 1));

	always_ff @(posedge clk_in or negedge rst_n) begin
		if (!rst_n) begin
			wdt_cnt <= 5'h0;
		end else if (wdt_tick) begin
			wdt_cnt <= 5'h0;
		end else begin
			wdt_cnt <= wdt_cnt + 5'h1;
		end
	end

	// ------------------------------------------------------------
	// power-down wake sequencer
	// ------------------------------------------------------------
	assign level_wake = |(level_mode[1:0] & enables[1:0] & ~lvl[1:0]);

	// a level must be seen on two watchdog samples; a pin 2 edge wakes
	// at once from WK_IDLE only; start-up always completes once begun
	always_ff @(posedge clk_in or negedge rst_n) begin
		if (!rst_n) begin
			wake_state <= WK_IDLE;
			start_cnt  <= '0;
			wake_out   <= 1'b0;
		end else begin
			wake_out <= 1'b0;
			unique case (wake_state)
				WK_IDLE: begin
					if (power_down_in && event_vec[2] && enables[2]) begin
						wake_state <= WK_START;
						start_cnt  <= '0;
					end else if (power_down_in && wdt_tick && level_wake) begin
						wake_state <= WK_SAMPLE;
					end
				end
				WK_SAMPLE: begin
					if (!power_down_in || (wdt_tick && !level_wake)) begin
						wake_state <= WK_IDLE;                      // noise rejected
					end else if (wdt_tick) begin
						wake_state <= WK_START;
						start_cnt  <= '0;
					end
				end
				WK_START: begin
					if (start_cnt == STARTUP_CYC - CNT_W'(1)) begin
						wake_state <= WK_IDLE;
						wake_out   <= 1'b1;
					end else begin
						start_cnt <= start_cnt + CNT_W'(1);
					end
				end
				default: wake_state <= WK_IDLE;             // unused code: back to rest
			endcase
		end
	end

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!rst_n);

	flag_set_a: assert property (event_vec[0] && !level_mode[0] |=> flags[0])
		else $error("pin zero event did not set its flag");
	level_clear_a: assert property (level_mode[1] |=> !flags[1])
		else $error("pin one flag not held clear in level mode");
	req_gate_a: assert property (irq_out[2] |-> $past(enables[2] && global_ie_in))
		else $error("pin two request without both enables");
	level_req_a: assert property (level_mode[0] && !lvl[0] && enables[0] && global_ie_in
		&& !power_down_in |=> irq_out[0])
		else $error("low level did not hold request");
	halt_edge_a: assert property (io_clk_halt_in |-> event_vec[1:0] == 2'h0)
		else $error("pin zero or one edge seen while halted");
	fall_sense_a: assert property (sense[0] == SENSE_FALLING && $fell(lvl[0])
		&& !io_clk_halt_in && !$past(io_clk_halt_in) |-> event_vec[0])
		else $error("falling edge on pin zero missed");
	p2_edge_a: assert property (p2_edge_sel && $rose(lvl[2]) && $stable(p2_edge_sel)
		|=> flags[2])
		else $error("pin two rising edge lost");
	two_sample_a: assert property (wake_state == WK_IDLE ##1 wake_state == WK_SAMPLE
		|-> ##[1:20] (wake_state != WK_SAMPLE))
		else $error("wake sampling overran a watchdog period");
	wake_end_a: assert property ($rose(wake_out) |-> $past(wake_state) == WK_START)
		else $error("wake pulse outside start-up");
	bus_ready_a: assert property (psel_in && !penable_in |=> pready_out)
		else $error("apb access phase not answered");

	set_wins_c: cover property (event_vec[0] && clr_vec[0] && !level_mode[0]);
	level_wake_c: cover property (wake_state == WK_SAMPLE ##[1:40] wake_out);
	p2_wake_c: cover property (power_down_in && event_vec[2] && enables[2]);
	soft_irq_c: cover property (pin_drive_en_in[1] && event_vec[1]);

endmodule : eipu_top

// [dv/eipu_pin_src.sv]
// partner model: three external sources on the interrupt pins.
// assumes the bench clock; pins idle high, as with a pull-up.
`timescale 1ns/10ps
module eipu_pin_src (
	// clock
	input  wire logic       clk_in,    // bench clock
	// pins
	output logic      [2:0] level_out  // pad levels, idle high
);
	initial level_out = 3'h7; // pulled up until a source drives low

	// change one pin just after an edge, then hold it until the next call
	// so a low level outlasts the cpu instruction and no pulse is under
	// one clock; a shorter pulse might be missed by the sampling
	task drive(input int idx, input logic val);
		@(posedge clk_in);
		level_out[idx] <= val;
	endtask : drive
endmodule : eipu_pin_src

// [dv/eipu_tb.sv]
// self-checking bench for the external pin interrupt unit.
// assumes eipu_pkg compiled first and the design's own assertions bound in.
`timescale 1ns/10ps
module eipu_tb;
	import eipu_pkg::*;
	// short start-up so a wake finishes in a few dozen cycles
	localparam logic [CNT_W-1:0] SU = CNT_W'(32'h20);
	// rows: pin[6:5] sense[4:3] level before[2] after[1] request[0]
	localparam logic [6:0] ROWS [11] = '{7'h15, 7'h12, 7'h1b, 7'h0d, 7'h35, 7'h3b,
		7'h3c, 7'h2b, 7'h55, 7'h5b, 7'h5c};
	localparam int FB [3] = '{6, 7, 5}; // enable and flag bit of each pin
	logic              clk_in, resetn_in, psel_in, penable_in, pwrite_in, pready_out;
	logic              pslverr_out, global_ie_in, io_clk_halt_in, power_down_in, wake_out;
	logic [ADDR_W-1:0] paddr_in;
	logic [31:0]       pwdata_in, prdata_out, rd;
	logic [2:0]        pin_level_in, pin_drive_en_in, pin_drive_val_in, vector_ack_in, irq_out;
	logic [7:0]        m;
	logic              er;
	int                fails, total_checks, cyc, wakes, p;

	eipu_top #(.STARTUP_CYC(SU)) eipu_top_i (.clk_in(clk_in), .resetn_in(resetn_in),
		.psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in),
		.paddr_in(paddr_in), .pwdata_in(pwdata_in), .prdata_out(prdata_out),
		.pready_out(pready_out), .pslverr_out(pslverr_out), .pin_level_in(pin_level_in),
		.pin_drive_en_in(pin_drive_en_in), .pin_drive_val_in(pin_drive_val_in),
		.global_ie_in(global_ie_in), .vector_ack_in(vector_ack_in),
		.io_clk_halt_in(io_clk_halt_in), .power_down_in(power_down_in),
		.irq_out(irq_out), .wake_out(wake_out));
	eipu_pin_src eipu_pin_src_i (.clk_in(clk_in), .level_out(pin_level_in));

	// ----------------------------------------
	// clock, hang guard, wake counter
	// ----------------------------------------
	always #25 clk_in = ~clk_in;
	// a hang is cut short well above the fewer than a thousand cycles needed
	always @(posedge clk_in) begin
		cyc <= cyc + 1;
		wakes <= wakes + 32'(wake_out === 1'b1);
		if (cyc == 8000) begin
			fails++;
			conclude();
		end
	end

	// ----------------------------------------
	// shared tasks
	// ----------------------------------------
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			fails++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk
	// one apb transfer; waits on pready with no assumed latency
	task apb(input logic w, input logic [7:0] a, input logic [7:0] d);
		psel_in <= 1'b1;
		penable_in <= 1'b0;
		pwrite_in <= w;
		paddr_in <= a;
		pwdata_in <= {24'h0, d};
		@(posedge clk_in);
		penable_in <= 1'b1;
		do @(posedge clk_in); while (pready_out !== 1'b1);
		rd = prdata_out;
		er = pslverr_out;
		psel_in <= 1'b0;
		penable_in <= 1'b0;
		@(posedge clk_in); // gap so the next setup is not in this time step
	endtask : apb
	task wait_cyc(input int n);
		repeat (n) @(posedge clk_in);
	endtask : wait_cyc
	task conclude();
		$display("checks %0d mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : conclude

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		{clk_in, resetn_in, psel_in, penable_in, pwrite_in, io_clk_halt_in} = 6'h0;
		{power_down_in, paddr_in, pwdata_in, pin_drive_en_in, vector_ack_in} = '0;
		{pin_drive_val_in, global_ie_in, fails, total_checks, cyc, wakes} = {3'h7, 1'b1, 128'h0};
		wait_cyc(12);
		resetn_in <= 1'b1;
		wait_cyc(4);
		// reset values, live pin levels (pins high) and the unmapped word
		for (int a = 0; a < 6; a++) begin
			apb(1'b0, 8'(a * 4), 8'h00);
			chk(rd, (a == 4) ? 32'h0c : 32'h0);
			chk(32'(er), 32'(a == 5));
		end
		apb(1'b1, OFS_PORT_D_LEVELS, 8'hf3); // read-only: write has no effect
		apb(1'b0, OFS_PORT_D_LEVELS, 8'h00);
		chk(rd, 32'h0c);
		// edge rows: only the pin's own enable set, so bit positions matter
		for (int i = 0; i < 11; i++) begin
			p = int'(ROWS[i][6:5]);
			m = 8'h01 << FB[p];
			apb(1'b1, OFS_PIN_ENABLES, 8'h00);
			// sense only in pin one's field for pin one, else in pin zero's field, so swapped fields are caught
			apb(1'b1, OFS_CPU_CONTROL, {4'h0, ROWS[i][4:3] & {2{p == 1}},
				ROWS[i][4:3] & {2{p != 1}}});
			apb(1'b1, OFS_CTRL_RST_STAT, {1'b0, ROWS[i][3], 6'h0});
			eipu_pin_src_i.drive(p, ROWS[i][2]);
			wait_cyc(6);
			apb(1'b1, OFS_PIN_FLAGS, 8'he0);
			apb(1'b1, OFS_PIN_ENABLES, m);
			eipu_pin_src_i.drive(p, ROWS[i][1]);
			wait_cyc(6);
			apb(1'b0, OFS_PIN_FLAGS, 8'h00);
			chk(rd, ROWS[i][0] ? 32'(m) : 32'h0);
			chk(32'(irq_out), 32'(3'(ROWS[i][0]) << p));
			vector_ack_in <= 3'h1 << p;
			@(posedge clk_in);
			vector_ack_in <= 3'h0;
			wait_cyc(4);
			chk(32'(irq_out), 32'h0);
			eipu_pin_src_i.drive(p, 1'b1);
		end
		// software interrupt: port drives pin zero low while the pad stays high
		apb(1'b1, OFS_CPU_CONTROL, 8'h0a);
		apb(1'b1, OFS_PIN_FLAGS, 8'he0);
		apb(1'b1, OFS_PIN_ENABLES, 8'h40);
		pin_drive_val_in <= 3'h6;
		pin_drive_en_in <= 3'h1;
		wait_cyc(6);
		chk(32'(irq_out), 32'h1);
		pin_drive_en_in <= 3'h0;
		// level mode: request while low, flag held clear, global enable gates
		apb(1'b1, OFS_CPU_CONTROL, 8'h00);
		eipu_pin_src_i.drive(0, 1'b0);
		wait_cyc(5);
		chk(32'(irq_out), 32'h1);
		apb(1'b0, OFS_PIN_FLAGS, 8'h00);
		chk(rd, 32'h0);
		global_ie_in <= 1'b0;
		wait_cyc(3);
		chk(32'(irq_out), 32'h0);
		global_ie_in <= 1'b1;
		eipu_pin_src_i.drive(0, 1'b1);
		wait_cyc(6);
		chk(32'(irq_out), 32'h0);
		// halted io clock: pin one edge ignored, pin two edge still caught
		apb(1'b1, OFS_CPU_CONTROL, 8'h08);
		apb(1'b1, OFS_CTRL_RST_STAT, 8'h00);
		apb(1'b1, OFS_PIN_FLAGS, 8'he0);
		apb(1'b1, OFS_PIN_ENABLES, 8'ha0);
		io_clk_halt_in <= 1'b1;
		eipu_pin_src_i.drive(1, 1'b0);
		eipu_pin_src_i.drive(2, 1'b0);
		wait_cyc(6);
		apb(1'b0, OFS_PIN_FLAGS, 8'h00);
		chk(rd, 32'h20);
		eipu_pin_src_i.drive(1, 1'b1);
		eipu_pin_src_i.drive(2, 1'b1);
		// power-down: a one-cycle low that falls between two watchdog samples is never sampled
		apb(1'b1, OFS_CPU_CONTROL, 8'h00);
		apb(1'b1, OFS_PIN_ENABLES, 8'h40);
		power_down_in <= 1'b1;
		eipu_pin_src_i.drive(0, 1'b0);
		eipu_pin_src_i.drive(0, 1'b1);
		wait_cyc(120);
		chk(32'(wakes), 32'h0);
		// low across two watchdog samples, gone before start-up ends
		eipu_pin_src_i.drive(0, 1'b0);
		wait_cyc(43);
		eipu_pin_src_i.drive(0, 1'b1);
		while (wake_out !== 1'b1) @(posedge clk_in);
		chk(32'(irq_out), 32'h0);
		power_down_in <= 1'b0;
		io_clk_halt_in <= 1'b0;
		wait_cyc(5);
		chk(32'(irq_out), 32'h0);
		chk(32'(wakes), 32'h1);
		// a one-cycle low on pin two still sets its flag
		apb(1'b1, OFS_PIN_FLAGS, 8'he0);
		eipu_pin_src_i.drive(2, 1'b0);
		eipu_pin_src_i.drive(2, 1'b1);
		wait_cyc(5);
		apb(1'b0, OFS_PIN_FLAGS, 8'h00);
		chk(rd, 32'h20);
		// mid-run reset while a level request is live on pin zero
		eipu_pin_src_i.drive(0, 1'b0);
		wait_cyc(5);
		chk(32'(irq_out), 32'h1);
		resetn_in <= 1'b0;
		wait_cyc(2);
		chk(32'({irq_out, wake_out, pready_out}), 32'h0);
		resetn_in <= 1'b1;
		wait_cyc(2);
		chk(32'(irq_out), 32'h0);
		wait_cyc(2);
		apb(1'b0, OFS_PIN_FLAGS, 8'h00);
		chk(rd, 32'h0);
		apb(1'b0, OFS_PIN_ENABLES, 8'h00);
		chk(rd, 32'h0);
		chk(32'(irq_out), 32'h0);
		eipu_pin_src_i.drive(0, 1'b1);
		conclude();
	end
endmodule : eipu_tb
